// ==== verilog/spio_pkg.sv ====
// spio_pkg: register map, bit positions, reset values and probe selector
// codes for the spare pin and signal probe block.
// assumes: every design file refers to these names as spio_pkg::name.
package spio_pkg;

  // ---------------------------------------------------------------
  // bus and pin widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8; // register address width
  localparam int DATA_W = 8; // register data width
  localparam int PIN_N = 8; // multiplexed spare pins
  localparam int SEL_W = 4; // probe selector width

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PIN_OUTPUT_ENABLES = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_PIN_OUTPUT_VALUES = 8'h45;
  localparam logic [ADDR_W-1:0] OFS_PIN_INPUT_LEVELS = 8'h46;
  localparam logic [ADDR_W-1:0] OFS_PROBE_OUTPUT_CONTROL = 8'h47;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_PIN_OUTPUT_ENABLES = 8'h00;
  localparam logic [DATA_W-1:0] RST_PIN_OUTPUT_VALUES = 8'h00;
  localparam logic [DATA_W-1:0] RST_PROBE_OUTPUT_CONTROL = 8'h00;
  localparam logic [PIN_N-1:0] RST_PIN_OE_N = 8'hFF; // all drivers off
  localparam logic [PIN_N-1:0] RST_PIN_OUT = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00; // idle / unmapped read

  // ---------------------------------------------------------------
  // pin bit order, shared by enables, values and input levels
  // ---------------------------------------------------------------
  localparam int BIT_SIG_INPUT = 7; // signal_input_pin
  localparam int BIT_CLOCK = 6; // clock_output_pin
  localparam int BIT_IFACE_B = 5; // interface_select_pin_b
  localparam int BIT_IFACE_A = 4; // interface_select_pin_a
  localparam int BIT_TCK = 3; // scan clock pin
  localparam int BIT_TDO = 0; // scan data out pin
  localparam logic [PIN_N-1:0] SCAN_PIN_MASK = 8'h0F; // tck, tms, tdi, tdo
  localparam logic [PIN_N-1:0] CLOCK_PIN_MASK = 8'h40;

  // ---------------------------------------------------------------
  // probe_output_control fields
  // ---------------------------------------------------------------
  localparam int BIT_FAST_PAD = 7; // fast_pad_switching
  localparam int SEL_HI = 3; // probe_selector msb
  localparam int SEL_LO = 0; // probe_selector lsb
  localparam logic [DATA_W-1:0] PROBE_CTRL_WMASK = 8'h8F; // bits 6..4 reserved

  // ---------------------------------------------------------------
  // probe selector codes
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_TRI_A = 4'h0;
  localparam logic [SEL_W-1:0] SEL_TRI_B = 4'h1;
  localparam logic [SEL_W-1:0] SEL_LOW = 4'h2;
  localparam logic [SEL_W-1:0] SEL_HIGH = 4'h3;
  localparam logic [SEL_W-1:0] SEL_TX_ENVELOPE = 4'h4;
  localparam logic [SEL_W-1:0] SEL_TX_ACTIVE = 4'h5;
  localparam logic [SEL_W-1:0] SEL_GENERIC = 4'h6;
  localparam logic [SEL_W-1:0] SEL_RX_ENVELOPE = 4'h7;
  localparam logic [SEL_W-1:0] SEL_RX_ACTIVE = 4'h8;
  localparam logic [SEL_W-1:0] SEL_RX_BIT = 4'h9;

endpackage

// ==== verilog/spio_sync.sv ====
// spio_sync: two flip-flop synchroniser for a bus of pin levels.
// assumes: each bit is an independent level from outside the clock domain;
// multi-bit coherence is not needed because every pin stands on its own.
`timescale 1ns/100ps
module spio_sync #(
  parameter int WIDTH = spio_pkg::PIN_N
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ---------------------------------------------------------------
  // stage one is read only by stage two, never by any other logic
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta; // first stage, may go metastable

  // both stages freeze with the clock enable like all other state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ==== verilog/spio_probe_mux.sv ====
// spio_probe_mux: drives the probe output pin from the probe selector.
// assumes: the debug signals come from logic on the same clock, so they
// are taken without synchronisation; pin output and enable are registered.
`timescale 1ns/100ps
module spio_probe_mux (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [spio_pkg::SEL_W-1:0] sel,
  input wire logic tx_envelope,
  input wire logic tx_active,
  input wire logic generic_internal_signal,
  input wire logic rx_envelope,
  input wire logic rx_active,
  input wire logic rx_bit,
  output logic probe_output_pin_out,
  output logic probe_output_pin_oe_n
);

  // ---------------------------------------------------------------
  // selector decode
  // ---------------------------------------------------------------
  logic next_out; // value to drive
  logic next_oe_n; // low while driving

  // every code that is not listed leaves the pin floating
  always_comb begin
    next_out = 1'b0;
    next_oe_n = 1'b0;
    unique case (sel)
      spio_pkg::SEL_TRI_A, spio_pkg::SEL_TRI_B: next_oe_n = 1'b1;
      spio_pkg::SEL_LOW: next_out = 1'b0;
      spio_pkg::SEL_HIGH: next_out = 1'b1;
      spio_pkg::SEL_TX_ENVELOPE: next_out = tx_envelope;
      spio_pkg::SEL_TX_ACTIVE: next_out = tx_active;
      spio_pkg::SEL_GENERIC: next_out = generic_internal_signal;
      // only meaningful for type A at 106 kBd; routed regardless
      spio_pkg::SEL_RX_ENVELOPE: next_out = rx_envelope;
      spio_pkg::SEL_RX_ACTIVE: next_out = rx_active;
      spio_pkg::SEL_RX_BIT: next_out = rx_bit;
      default: next_oe_n = 1'b1; // undefined codes float the pin
    endcase
  end

  // ---------------------------------------------------------------
  // pin register: one cycle latency, no glitches on the pad
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      probe_output_pin_out <= 1'b0;
      probe_output_pin_oe_n <= 1'b1;
    end else if (ce) begin
      probe_output_pin_out <= next_out;
      probe_output_pin_oe_n <= next_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_probe_float;
    @(posedge clk) disable iff (!arst_n)
    ce && (sel <= spio_pkg::SEL_TRI_B || sel > spio_pkg::SEL_RX_BIT) |=> probe_output_pin_oe_n;
  endproperty
  a_probe_float: assert property (p_probe_float)
    else $error("probe pin driven for a floating selector code");

  property p_probe_const;
    @(posedge clk) disable iff (!arst_n)
    ce && (sel == spio_pkg::SEL_LOW || sel == spio_pkg::SEL_HIGH)
      |=> !probe_output_pin_oe_n && probe_output_pin_out == $past(sel[0]);
  endproperty
  a_probe_const: assert property (p_probe_const)
    else $error("probe pin constant level wrong");

  property p_probe_tx;
    @(posedge clk) disable iff (!arst_n)
    ce && sel == spio_pkg::SEL_TX_ACTIVE |=> !probe_output_pin_oe_n && probe_output_pin_out == $past(tx_active);
  endproperty
  a_probe_tx: assert property (p_probe_tx)
    else $error("probe pin does not follow transmit-active");

  property p_probe_rx;
    @(posedge clk) disable iff (!arst_n)
    ce && sel == spio_pkg::SEL_RX_BIT |=> !probe_output_pin_oe_n && probe_output_pin_out == $past(rx_bit);
  endproperty
  a_probe_rx: assert property (p_probe_rx)
    else $error("probe pin does not follow received bit stream");

endmodule

// ==== verilog/spio_top.sv ====
// spio_top: spare pin general-purpose control and signal probe output.
// assumes: one 20 MHz clock, asynchronous active-low reset, a simple
// register port whose strobes are one cycle long, and pads outside that
// resolve each pin from its output and active-low output enable.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module spio_top #(
  parameter int ADDR_W = spio_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [spio_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [spio_pkg::DATA_W-1:0] reg_rdata,
  // configuration and dedicated functions
  input wire logic boundary_scan_active,
  input wire logic clk_out_func,
  // the eight spare pins, bit order as the enable register
  input wire logic [spio_pkg::PIN_N-1:0] pin_in,
  output logic [spio_pkg::PIN_N-1:0] pin_out,
  output logic [spio_pkg::PIN_N-1:0] pin_oe_n,
  // internal debug signals for the probe
  input wire logic tx_envelope,
  input wire logic tx_active,
  input wire logic generic_internal_signal,
  input wire logic rx_envelope,
  input wire logic rx_active,
  input wire logic rx_bit,
  // probe pin and pad speed
  output logic probe_output_pin_out,
  output logic probe_output_pin_oe_n,
  output logic fast_pad_switching
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // address match, shared by write decode, read decode and checks
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [spio_pkg::DATA_W-1:0] pin_output_enables; // one driver enable per pin
  logic [spio_pkg::DATA_W-1:0] pin_output_values; // one output level per pin
  logic [spio_pkg::DATA_W-1:0] probe_output_control; // speed and selector
  logic [spio_pkg::PIN_N-1:0] pin_input_levels; // synchronised pin levels
  logic [spio_pkg::PIN_N-1:0] drive_en; // effective driver enables
  logic [spio_pkg::PIN_N-1:0] next_pin_out; // pin levels for next edge
  logic [spio_pkg::PIN_N-1:0] next_pin_oe_n; // pin enables for next edge
  logic [spio_pkg::DATA_W-1:0] next_reg_rdata; // read mux result

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // enable register: all eight bits read/write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_output_enables <= spio_pkg::RST_PIN_OUTPUT_ENABLES;
    end else if (ce && reg_we && reg_hit(reg_addr, spio_pkg::OFS_PIN_OUTPUT_ENABLES)) begin
      pin_output_enables <= reg_wdata;
    end
  end

  // output value register: stored even for pins whose driver is off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_output_values <= spio_pkg::RST_PIN_OUTPUT_VALUES;
    end else if (ce && reg_we && reg_hit(reg_addr, spio_pkg::OFS_PIN_OUTPUT_VALUES)) begin
      pin_output_values <= reg_wdata;
    end
  end

  // probe control: reserved bits are never stored, so they read as zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      probe_output_control <= spio_pkg::RST_PROBE_OUTPUT_CONTROL;
    end else if (ce && reg_we && reg_hit(reg_addr, spio_pkg::OFS_PROBE_OUTPUT_CONTROL)) begin
      probe_output_control <= reg_wdata & spio_pkg::PROBE_CTRL_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // the input level register ignores writes; unmapped addresses read zero
  always_comb begin
    next_reg_rdata = spio_pkg::RD_ZERO;
    if (reg_re) begin
      if (reg_hit(reg_addr, spio_pkg::OFS_PIN_OUTPUT_ENABLES)) begin
        next_reg_rdata = pin_output_enables;
      end else if (reg_hit(reg_addr, spio_pkg::OFS_PIN_OUTPUT_VALUES)) begin
        next_reg_rdata = pin_output_values;
      end else if (reg_hit(reg_addr, spio_pkg::OFS_PIN_INPUT_LEVELS)) begin
        next_reg_rdata = pin_input_levels;
      end else if (reg_hit(reg_addr, spio_pkg::OFS_PROBE_OUTPUT_CONTROL)) begin
        next_reg_rdata = probe_output_control;
      end
    end
  end

  // read data stand for exactly the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= spio_pkg::RD_ZERO;
    end else if (ce) begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ---------------------------------------------------------------
  // pin input path
  // ---------------------------------------------------------------
  // pad levels are asynchronous, so two flops before anything reads them
  spio_sync #(
    .WIDTH(spio_pkg::PIN_N)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .d(pin_in),
    .q(pin_input_levels)
  );

  // ---------------------------------------------------------------
  // pin output path
  // ---------------------------------------------------------------
  // scan pins belong to the scan port while boundary scan is active,
  // so their enable bits are masked off then
  always_comb begin
    drive_en = pin_output_enables;
    if (boundary_scan_active) begin
      drive_en = pin_output_enables & ~spio_pkg::SCAN_PIN_MASK;
    end
  end

  // values always come from the value register; the clock pin alone
  // carries its dedicated clock while its enable bit is clear
  always_comb begin
    next_pin_out = pin_output_values;
    next_pin_oe_n = ~drive_en;
    if (!pin_output_enables[spio_pkg::BIT_CLOCK]) begin
      next_pin_out[spio_pkg::BIT_CLOCK] = clk_out_func;
      next_pin_oe_n[spio_pkg::BIT_CLOCK] = 1'b0;
    end
  end

  // registered pad drive; note the clock pin's dedicated clock is
  // retimed here, so it lags clk_out_func by one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= spio_pkg::RST_PIN_OUT;
      pin_oe_n <= spio_pkg::RST_PIN_OE_N;
    end else if (ce) begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // pad speed
  // ---------------------------------------------------------------
  // fast pads raise peak supply current when many pins switch at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_pad_switching <= 1'b0;
    end else if (ce) begin
      fast_pad_switching <= probe_output_control[spio_pkg::BIT_FAST_PAD];
    end
  end

  // ---------------------------------------------------------------
  // probe output
  // ---------------------------------------------------------------
  spio_probe_mux u_probe (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .sel(probe_output_control[spio_pkg::SEL_HI:spio_pkg::SEL_LO]),
    .tx_envelope(tx_envelope),
    .tx_active(tx_active),
    .generic_internal_signal(generic_internal_signal),
    .rx_envelope(rx_envelope),
    .rx_active(rx_active),
    .rx_bit(rx_bit),
    .probe_output_pin_out(probe_output_pin_out),
    .probe_output_pin_oe_n(probe_output_pin_oe_n)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_sig_input_drive;
    @(posedge clk) disable iff (!arst_n)
    ce |=> pin_oe_n[spio_pkg::BIT_SIG_INPUT] == !$past(pin_output_enables[spio_pkg::BIT_SIG_INPUT]);
  endproperty
  a_sig_input_drive: assert property (p_sig_input_drive)
    else $error("signal input pin driver does not follow its enable");

  property p_clock_pin_gpio;
    @(posedge clk) disable iff (!arst_n)
    ce && pin_output_enables[spio_pkg::BIT_CLOCK]
      |=> !pin_oe_n[spio_pkg::BIT_CLOCK] && pin_out[spio_pkg::BIT_CLOCK] == $past(pin_output_values[spio_pkg::BIT_CLOCK]);
  endproperty
  a_clock_pin_gpio: assert property (p_clock_pin_gpio)
    else $error("clock pin not driven from the value register");

  // the pad flops still load reset values on the release edge, so that edge starts no attempt
  property p_clock_pin_func;
    @(posedge clk) disable iff (!arst_n)
    arst_n && ce && !pin_output_enables[spio_pkg::BIT_CLOCK]
      |=> !pin_oe_n[spio_pkg::BIT_CLOCK] && pin_out[spio_pkg::BIT_CLOCK] == $past(clk_out_func);
  endproperty
  a_clock_pin_func: assert property (p_clock_pin_func)
    else $error("clock pin lost its dedicated clock");

  property p_iface_drive;
    @(posedge clk) disable iff (!arst_n)
    ce |=> pin_oe_n[spio_pkg::BIT_IFACE_B:spio_pkg::BIT_IFACE_A]
      == ~$past(pin_output_enables[spio_pkg::BIT_IFACE_B:spio_pkg::BIT_IFACE_A]);
  endproperty
  a_iface_drive: assert property (p_iface_drive)
    else $error("interface select drivers do not follow their enables");

  property p_scan_locked;
    @(posedge clk) disable iff (!arst_n)
    ce && boundary_scan_active |=> &pin_oe_n[spio_pkg::BIT_TCK:spio_pkg::BIT_TDO];
  endproperty
  a_scan_locked: assert property (p_scan_locked)
    else $error("scan pin driven while boundary scan is active");

  property p_scan_free;
    @(posedge clk) disable iff (!arst_n)
    ce && !boundary_scan_active
      |=> pin_oe_n[spio_pkg::BIT_TCK:spio_pkg::BIT_TDO] == ~$past(pin_output_enables[spio_pkg::BIT_TCK:spio_pkg::BIT_TDO]);
  endproperty
  a_scan_free: assert property (p_scan_free)
    else $error("scan pin driver does not follow its enable");

  property p_out_value;
    @(posedge clk) disable iff (!arst_n)
    ce |=> (pin_out & ~spio_pkg::CLOCK_PIN_MASK) == ($past(pin_output_values) & ~spio_pkg::CLOCK_PIN_MASK);
  endproperty
  a_out_value: assert property (p_out_value)
    else $error("pin output differs from the value register");

  property p_input_read;
    @(posedge clk) disable iff (!arst_n)
    ce && reg_re && reg_hit(reg_addr, spio_pkg::OFS_PIN_INPUT_LEVELS) |=> reg_rdata == $past(pin_input_levels);
  endproperty
  a_input_read: assert property (p_input_read)
    else $error("input level read returned wrong data");

  property p_fast_pad;
    @(posedge clk) disable iff (!arst_n)
    ce |=> fast_pad_switching == $past(probe_output_control[spio_pkg::BIT_FAST_PAD]);
  endproperty
  a_fast_pad: assert property (p_fast_pad)
    else $error("pad speed output does not follow its control bit");

  property p_reserved_zero;
    @(posedge clk) disable iff (!arst_n)
    ce && reg_re && reg_hit(reg_addr, spio_pkg::OFS_PROBE_OUTPUT_CONTROL)
      |=> reg_rdata == ($past(probe_output_control) & spio_pkg::PROBE_CTRL_WMASK);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved probe control bits read as non-zero");

  property p_enable_rw;
    @(posedge clk) disable iff (!arst_n)
    ce && reg_we && reg_hit(reg_addr, spio_pkg::OFS_PIN_OUTPUT_ENABLES)
      ##1 ce && reg_re && reg_hit(reg_addr, spio_pkg::OFS_PIN_OUTPUT_ENABLES)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_enable_rw: assert property (p_enable_rw)
    else $error("enable register read back differs from write");

endmodule

// ==== test/spio_board.sv ====
// spio_board: board circuitry hanging on the eight spare pins.
// assumes: device pads use active-low enables; the board drives only idle pins.
`timescale 1ns/100ps
// ------------------------------------------------------------
// resolved pin levels
// ------------------------------------------------------------
module spio_board (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] board_val,
  output logic [7:0] pin_level
);
  // the board level changes every setup, so a released pin never shows
  // a stale device value by accident
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = pin_oe_n[i] ? board_val[i] : pin_out[i];
    end
  end
endmodule

// ==== test/spio_top_tb.sv ====
// spio_top_tb: self-checking bench for the spare pin and probe block.
// assumes: spio_pkg and the design compiled first, board model beside it.
`timescale 1ns/100ps
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end
module spio_top_tb;
  // ------------------------------------------------------------
  // stimulus, observation and model state
  // ------------------------------------------------------------
  logic clk = 0;
  logic arst_n = 0;
  logic ce = 1; // dropped once to check that a write is lost
  logic [7:0] reg_addr = 0, reg_wdata = 0;
  logic reg_we = 0, reg_re = 0, bscan = 0, cof = 0;
  logic [5:0] dbg = 0; // tx env, tx act, generic, rx env, rx act, rx bit
  logic [7:0] ext = 0, reg_rdata, pin_out, pin_oe_n, pin_level;
  logic probe_output_pin_out, probe_output_pin_oe_n, fast_pad_switching;
  int m_en, m_val, m_ctl; // behavioural register model
  int seed = 75;
  int err_count = 0;
  int samples_checked = 0;

  always #25 clk = ~clk; // 20 MHz

  spio_top dut (.clk(clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .boundary_scan_active(bscan),
    .clk_out_func(cof), .pin_in(pin_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .tx_envelope(dbg[0]), .tx_active(dbg[1]), .generic_internal_signal(dbg[2]),
    .rx_envelope(dbg[3]), .rx_active(dbg[4]), .rx_bit(dbg[5]),
    .probe_output_pin_out(probe_output_pin_out), .probe_output_pin_oe_n(probe_output_pin_oe_n),
    .fast_pad_switching(fast_pad_switching));
  spio_board board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_val(ext), .pin_level(pin_level));

  // ------------------------------------------------------------
  // register port tasks
  // ------------------------------------------------------------
  // one-cycle write strobe, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  // ------------------------------------------------------------
  // expected pins and probe from the model
  // ------------------------------------------------------------
  task automatic chk_pins();
    logic [7:0] eoe, eout;
    eoe = ~m_en[7:0];
    eoe[6] = 1'b0; // clock pin drives either the clock or the value bit
    if (bscan) eoe[3:0] = 4'hF; // scan owns its pins
    eout = m_val[7:0];
    if (!m_en[6]) eout[6] = cof;
    `CHK(pin_oe_n, eoe)
    `CHK(pin_out, eout)
    rd(8'h46, (~eoe & eout) | (eoe & ext));
  endtask
  task automatic chk_probe();
    logic [3:0] s;
    s = m_ctl[3:0];
    `CHK(fast_pad_switching, m_ctl[7])
    `CHK(probe_output_pin_oe_n, (s < 2 || s > 9))
    if (s == 2 || s == 3) `CHK(probe_output_pin_out, s[0])
    if (s > 3 && s < 10) `CHK(probe_output_pin_out, dbg[s-4])
  endtask

  // ------------------------------------------------------------
  // verdict and watchdog
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hang counts as a mismatch and ends the run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h44, 8'h00);
    rd(8'h45, 8'h00);
    rd(8'h47, 8'h00);
    `CHK(probe_output_pin_oe_n, 1'b1)
    // first sixteen passes walk every selector code, the rest are random
    for (int it = 0; it < 48; it++) begin
      @(posedge clk);
      bscan <= 1'($random(seed));
      cof <= 1'($random(seed));
      dbg <= 6'($random(seed));
      ext <= 8'($random(seed));
      m_en = $random(seed) & 255;
      m_val = $random(seed) & 255;
      m_ctl = (it < 16) ? (it | (($random(seed) & 1) << 7)) : ($random(seed) & 255);
      wr(8'h44, m_en[7:0]);
      wr(8'h45, m_val[7:0]);
      wr(8'h47, m_ctl[7:0]);
      wr(8'h46, 8'hA5); // read-only place, must be ignored
      wr(8'h48, 8'h5A); // unmapped place, must be ignored
      m_ctl = m_ctl & 'h8F; // reserved bits are not kept
      repeat (2) @(posedge clk);
      #1;
      chk_pins();
      chk_probe();
      rd(8'h44, m_en[7:0]);
      rd(8'h45, m_val[7:0]);
      rd(8'h47, m_ctl[7:0]);
      rd(8'h48, 8'h00);
    end
    // write then read with no gap, then the read data fall back to zero
    m_en = $random(seed) & 255;
    @(posedge clk);
    reg_addr <= 8'h44;
    reg_wdata <= m_en[7:0];
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    `CHK(reg_rdata, m_en[7:0])
    @(posedge clk);
    #1;
    `CHK(reg_rdata, 8'h00)
    // a write while the clock enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h44, ~m_en[7:0]);
    ce <= 1'b1;
    rd(8'h44, m_en[7:0]);
    // reset in mid-run drops every driver at once
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    `CHK(pin_oe_n, 8'hFF)
    `CHK(probe_output_pin_oe_n, 1'b1)
    // second release: registers come back at their reset values
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h44, 8'h00);
    rd(8'h47, 8'h00);
    `CHK(fast_pad_switching, 1'b0)
    stop_test();
  end
endmodule
